// file: inc/swm_pkg.sv
// package of constants and types for the signed word multiply and accumulator negate unit
package swm_pkg;
	// operation select
	typedef enum logic [1:0] {
		SWM_OP_NONE = 2'b00,
		SWM_OP_MULW = 2'b01,
		SWM_OP_NEGA = 2'b10
	} swm_op_t;
	// source kinds chosen by the middle field of the final opcode byte
	typedef enum logic [2:0] {
		SWM_SRC_REG = 3'b000,
		SWM_SRC_IMM = 3'b001,
		SWM_SRC_DIR = 3'b010,
		SWM_SRC_IDX = 3'b011,
		SWM_SRC_REL = 3'b100,
		SWM_SRC_IND = 3'b101,
		SWM_SRC_BAD = 3'b111
	} swm_src_t;
	// final opcode byte layout
	localparam int SWM_LOW_POS = 0;
	localparam int SWM_MID_POS = 3;
	localparam logic [2:0] SWM_MULW_LOW = 3'h2;
	// middle field codes
	localparam logic [2:0] SWM_RR_FIRST_PAIR = 3'h0;
	localparam logic [2:0] SWM_RR_EXT_WORD = 3'h2;
	localparam logic [2:0] SWM_RR_INDEX_HALF = 3'h4;
	localparam logic [2:0] SWM_MID_IMM_REL = 3'h6;
	localparam logic [2:0] SWM_XY_FIRST_INDEX = 3'h0;
	localparam logic [2:0] SWM_XY_SECOND_INDEX = 3'h2;
	// prefix selects the flavour of codes 000/010/110
	localparam logic [1:0] SWM_PFX_PLAIN = 2'h0;
	localparam logic [1:0] SWM_PFX_DD = 2'h1;
	localparam logic [1:0] SWM_PFX_FD = 2'h2;
	// data values
	localparam logic [7:0] SWM_ACC_MIN = 8'h80;
	localparam logic [7:0] SWM_ACC_ZERO = 8'h00;
	localparam int SWM_WORD_SIGN_POS = 15;
	// flag bit positions in the flag byte
	localparam int SWM_F_C = 0;
	localparam int SWM_F_N = 1;
	localparam int SWM_F_V = 2;
	localparam int SWM_F_H = 4;
	localparam int SWM_F_Z = 6;
	localparam int SWM_F_S = 7;
	// reset values and latency
	localparam logic [15:0] SWM_WORD_RESET = 16'h0000;
	localparam logic [7:0] SWM_BYTE_RESET = 8'h00;
	localparam int SWM_LATENCY_CYCLES = 1;
endpackage : swm_pkg

// file: verilog/swm_decode.sv
// decoder of the final opcode byte for the signed word multiply
`timescale 1ns/1ps
`default_nettype none
module swm_decode (
	input wire logic [7:0] i_opcode,
	input wire logic [1:0] i_prefix,
	output logic o_is_mulw,
	output swm_pkg::swm_src_t o_src,
	output logic o_ext_pair,
	output logic o_second_index
);
	wire logic [2:0] low_field = i_opcode[swm_pkg::SWM_LOW_POS +: 3];
	wire logic [2:0] mid_field = i_opcode[swm_pkg::SWM_MID_POS +: 3];
	wire logic plain = (i_prefix == swm_pkg::SWM_PFX_PLAIN);
	wire logic dd = (i_prefix == swm_pkg::SWM_PFX_DD);
	wire logic fd = (i_prefix == swm_pkg::SWM_PFX_FD);

	// the multiply family is marked by 010 in the low field
	assign o_is_mulw = (low_field == swm_pkg::SWM_MULW_LOW);
	// the prefix disambiguates codes that mean different sources
	assign o_src = !o_is_mulw ? swm_pkg::SWM_SRC_BAD :
		(plain && (mid_field == swm_pkg::SWM_RR_FIRST_PAIR ||
			mid_field == swm_pkg::SWM_RR_EXT_WORD)) ? swm_pkg::SWM_SRC_REG :
		(mid_field == swm_pkg::SWM_RR_INDEX_HALF) ? swm_pkg::SWM_SRC_REG :
		(fd && (mid_field == swm_pkg::SWM_XY_FIRST_INDEX ||
			mid_field == swm_pkg::SWM_XY_SECOND_INDEX)) ? swm_pkg::SWM_SRC_IDX :
		(fd && mid_field == swm_pkg::SWM_MID_IMM_REL) ? swm_pkg::SWM_SRC_IMM :
		(dd && mid_field == swm_pkg::SWM_MID_IMM_REL) ? swm_pkg::SWM_SRC_REL :
		(dd && mid_field == swm_pkg::SWM_RR_EXT_WORD) ? swm_pkg::SWM_SRC_DIR :
		(dd && mid_field == swm_pkg::SWM_RR_FIRST_PAIR) ? swm_pkg::SWM_SRC_IND :
		swm_pkg::SWM_SRC_BAD;
	assign o_ext_pair = (mid_field == swm_pkg::SWM_RR_EXT_WORD);
	assign o_second_index = (mid_field == swm_pkg::SWM_XY_SECOND_INDEX);
endmodule : swm_decode
`default_nettype wire

// file: verilog/swm_unit.sv
// signed word multiply and accumulator negate execution unit
// Contract
// - product upper half goes to extension word, lower half to primary word
// - both multiply operands are signed 16-bit; source comes from several modes
// - carry set when product falls outside signed 16-bit range
// - carry clear when upper word holds only sign copies
// - multiply sets sign and zero, clears overflow, keeps half-carry and subtract
// - register field 000 picks first general pair, 010 extension word
// - indexed field 000 picks first index plus displacement, 010 second index
// - accumulator negate replaces accumulator with its twos complement
// - accumulator 80 hex stays unchanged and sets overflow
// - negate sets sign and zero from result, always sets subtract
// - negate half-carry reflects borrow into bit 4
// - negate carry set when accumulator was nonzero before
`timescale 1ns/1ps
`default_nettype none
module swm_unit (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_start,
	input wire logic i_neg_acc,
	input wire logic [7:0] i_opcode,
	input wire logic [1:0] i_prefix,
	input wire logic [15:0] i_primary_word,
	input wire logic [15:0] i_first_general_pair,
	input wire logic [15:0] i_extension_word,
	input wire logic [15:0] i_index_half,
	input wire logic [15:0] i_mem_word,
	input wire logic [15:0] i_first_index,
	input wire logic [15:0] i_second_index,
	input wire logic [15:0] i_disp,
	input wire logic [7:0] i_acc,
	input wire logic [7:0] i_flags,
	output logic o_done,
	output logic o_illegal,
	output logic o_word_we,
	output logic [15:0] o_primary_word,
	output logic [15:0] o_extension_word,
	output logic o_acc_we,
	output logic [7:0] o_acc,
	output logic [7:0] o_flags,
	output logic o_addr_valid,
	output logic [15:0] o_addr
);
	// decoded source of the multiply
	swm_pkg::swm_src_t src;
	logic is_mulw;
	logic ext_pair;
	logic second_index;

	swm_decode u_dec (
		.i_opcode(i_opcode),
		.i_prefix(i_prefix),
		.o_is_mulw(is_mulw),
		.o_src(src),
		.o_ext_pair(ext_pair),
		.o_second_index(second_index)
	);

	// operand selection; memory forms take the word the fetch path supplies
	wire logic [15:0] reg_operand = (src == swm_pkg::SWM_SRC_REG &&
		i_prefix != swm_pkg::SWM_PFX_PLAIN) ? i_index_half :
		ext_pair ? i_extension_word : i_first_general_pair;
	wire logic [15:0] src_word = (src == swm_pkg::SWM_SRC_REG) ? reg_operand :
		i_mem_word;
	wire logic [15:0] index_base = second_index ? i_second_index : i_first_index;
	wire logic [15:0] eff_addr = index_base + i_disp;
	wire logic mul_go = i_start && !i_neg_acc && is_mulw &&
		(src != swm_pkg::SWM_SRC_BAD);
	wire logic bad_go = i_start && !i_neg_acc && !mul_go;

	// signed product and its range check
	wire logic signed [31:0] product = $signed(i_primary_word) * $signed(src_word);
	wire logic [15:0] prod_hi = product[31:16];
	wire logic [15:0] prod_lo = product[15:0];
	wire logic fits_low = (prod_hi == {16{prod_lo[swm_pkg::SWM_WORD_SIGN_POS]}});
	wire logic [7:0] mul_flags;
	assign mul_flags[swm_pkg::SWM_F_S] = product[31];
	assign mul_flags[swm_pkg::SWM_F_Z] = (product == 32'sh0000_0000);
	assign mul_flags[5] = i_flags[5];
	assign mul_flags[swm_pkg::SWM_F_H] = i_flags[swm_pkg::SWM_F_H];
	assign mul_flags[3] = i_flags[3];
	assign mul_flags[swm_pkg::SWM_F_V] = 1'b0;
	assign mul_flags[swm_pkg::SWM_F_N] = i_flags[swm_pkg::SWM_F_N];
	assign mul_flags[swm_pkg::SWM_F_C] = !fits_low;

	// accumulator negate: 0 - a, borrow into bit 4 comes from low nibble
	wire logic [7:0] neg_res = 8'h00 - i_acc;
	wire logic [7:0] neg_flags;
	assign neg_flags[swm_pkg::SWM_F_S] = neg_res[7];
	assign neg_flags[swm_pkg::SWM_F_Z] = (neg_res == swm_pkg::SWM_ACC_ZERO);
	assign neg_flags[5] = i_flags[5];
	assign neg_flags[swm_pkg::SWM_F_H] = (i_acc[3:0] != 4'h0);
	assign neg_flags[3] = i_flags[3];
	// overflow only for the most negative value, which negates to itself
	assign neg_flags[swm_pkg::SWM_F_V] = (i_acc == swm_pkg::SWM_ACC_MIN);
	assign neg_flags[swm_pkg::SWM_F_N] = 1'b1;
	assign neg_flags[swm_pkg::SWM_F_C] = (i_acc != swm_pkg::SWM_ACC_ZERO);

	wire logic neg_go = i_start && i_neg_acc;

	// result registers, one cycle after the start pulse
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_done <= 1'b0;
			o_illegal <= 1'b0;
			o_word_we <= 1'b0;
			o_acc_we <= 1'b0;
			o_primary_word <= swm_pkg::SWM_WORD_RESET;
			o_extension_word <= swm_pkg::SWM_WORD_RESET;
			o_acc <= swm_pkg::SWM_BYTE_RESET;
			o_flags <= swm_pkg::SWM_BYTE_RESET;
			o_addr_valid <= 1'b0;
			o_addr <= swm_pkg::SWM_WORD_RESET;
		end else if (i_ce) begin
			o_done <= mul_go || neg_go;
			o_illegal <= bad_go;
			o_word_we <= mul_go;
			o_acc_we <= neg_go;
			o_addr_valid <= mul_go && (src == swm_pkg::SWM_SRC_IDX);
			if (mul_go) begin
				o_extension_word <= prod_hi;
				o_primary_word <= prod_lo;
				o_flags <= mul_flags;
				o_addr <= eff_addr;
			end
			if (neg_go) begin
				o_acc <= neg_res;
				o_flags <= neg_flags;
			end
		end
	end

	// checks
	mul_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mul_go |=> o_word_we && $signed({o_extension_word, o_primary_word}) ==
			$signed($past(i_primary_word)) * $signed($past(src_word)))
		else $error("multiply result misplaced");
	mul_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mul_go |=> o_flags[swm_pkg::SWM_F_C] ==
			(o_extension_word != {16{o_primary_word[15]}}))
		else $error("multiply carry wrong");
	mul_nocarry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mul_go && fits_low |=> !o_flags[swm_pkg::SWM_F_C])
		else $error("multiply carry not cleared");
	mul_flags_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mul_go |=> !o_flags[swm_pkg::SWM_F_V] &&
			o_flags[swm_pkg::SWM_F_H] == $past(i_flags[swm_pkg::SWM_F_H]) &&
			o_flags[swm_pkg::SWM_F_S] == o_extension_word[15])
		else $error("multiply flags wrong");
	reg_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		src == swm_pkg::SWM_SRC_REG && i_prefix == swm_pkg::SWM_PFX_PLAIN &&
		i_opcode[5:3] == swm_pkg::SWM_RR_EXT_WORD |-> src_word == i_extension_word)
		else $error("register pair select wrong");
	idx_select_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && mul_go && src == swm_pkg::SWM_SRC_IDX && i_opcode[5:3] == 3'h2
		|=> o_addr_valid && o_addr == $past(i_second_index) + $past(i_disp))
		else $error("index select wrong");
	neg_result_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && neg_go |=> o_acc_we && o_acc + $past(i_acc) == 8'h00 &&
			o_flags[swm_pkg::SWM_F_N])
		else $error("negate result wrong");
	neg_min_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && neg_go && i_acc == 8'h80 |=> o_acc == 8'h80 &&
			o_flags[swm_pkg::SWM_F_V])
		else $error("negate of 80 wrong");
	neg_sz_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && neg_go |=> o_flags[swm_pkg::SWM_F_S] == o_acc[7] &&
			o_flags[swm_pkg::SWM_F_Z] == (o_acc == 8'h00))
		else $error("negate sign or zero wrong");
	neg_half_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && neg_go |=> o_flags[swm_pkg::SWM_F_H] == ($past(i_acc[3:0]) != 4'h0))
		else $error("negate half carry wrong");
	neg_carry_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && neg_go |=> o_flags[swm_pkg::SWM_F_C] == ($past(i_acc) != 8'h00))
		else $error("negate carry wrong");
	mul_decode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_start && !i_neg_acc && i_opcode[2:0] != 3'h2 |=> o_illegal && !o_word_we)
		else $error("multiply decode wrong");
endmodule : swm_unit
`default_nettype wire

// file: tb/signed_word_multiply_negate_tb.sv
// self-checking bench for the signed word multiply and accumulator negate unit
`timescale 1ns/1ps
`default_nettype none
module signed_word_multiply_negate_tb;
	typedef struct {logic neg; logic [7:0] opc; logic [1:0] pfx; logic [15:0] pw, src, xa;
		logic [7:0] acc;} swm_row_t;
	logic i_clk = 0, i_rst_n = 0, i_ce = 1, i_start = 0, i_neg_acc = 0;
	logic [7:0] i_opcode = 8'h00, i_acc = 8'h00, i_flags = 8'h00;
	logic [1:0] i_prefix = 2'h0;
	logic [15:0] i_primary_word = 16'h0000, gp = 16'h0003, ew = 16'hfffe, ih = 16'h0100;
	logic [15:0] mw = 16'h8000, xa1 = 16'h1000, xa2 = 16'h2000, dsp = 16'h0010;
	logic o_done, o_illegal, o_word_we, o_acc_we, o_addr_valid;
	logic [15:0] o_primary_word, o_extension_word, o_addr;
	logic [7:0] o_acc, o_flags;
	int num_errors = 0;
	int checked = 0;
	swm_row_t rows [15];

	always #2.5 i_clk = ~i_clk;

	swm_unit DUT (.i_clk, .i_rst_n, .i_ce, .i_start, .i_neg_acc, .i_opcode, .i_prefix,
		.i_primary_word, .i_first_general_pair(gp), .i_extension_word(ew), .i_index_half(ih),
		.i_mem_word(mw), .i_first_index(xa1), .i_second_index(xa2), .i_disp(dsp), .i_acc,
		.i_flags, .o_done, .o_illegal, .o_word_we, .o_primary_word, .o_extension_word,
		.o_acc_we, .o_acc, .o_flags, .o_addr_valid, .o_addr);

	// comparisons, one per result width
	task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp_word
	task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_word(nm, {8'h00, e}, {8'h00, g});
	endtask : cmp_byte
	task automatic cmp_bit(input string nm, input logic e, input logic g);
		cmp_word(nm, {15'h0000, e}, {15'h0000, g});
	endtask : cmp_bit

	// start stays high between rows, so rows run back to back
	task automatic run(input swm_row_t r, input logic [7:0] fin);
		logic signed [31:0] p;
		logic [7:0] n;
		logic [7:0] ef;
		p = $signed(r.pw) * $signed(r.src);
		n = 8'h00 - r.acc;
		i_start = 1;
		i_neg_acc = r.neg;
		i_opcode = r.opc;
		i_prefix = r.pfx;
		i_primary_word = r.pw;
		i_acc = r.acc;
		i_flags = fin;
		@(negedge i_clk);
		cmp_bit("done", 1'b1, o_done);
		if (r.neg) begin
			ef = {n[7], n == 8'h00, fin[5], r.acc[3:0] != 4'h0, fin[3], r.acc == 8'h80, 1'b1,
				r.acc != 8'h00};
			cmp_bit("acc_we", 1'b1, o_acc_we);
			cmp_byte("acc", n, o_acc);
			cmp_byte("neg_flags", ef, o_flags);
		end else begin
			ef = {p[31], p == 0, fin[5], fin[4], fin[3], 1'b0, fin[1], p[31:15] != {17{p[31]}}};
			cmp_bit("word_we", 1'b1, o_word_we);
			cmp_word("low", p[15:0], o_primary_word);
			cmp_word("high", p[31:16], o_extension_word);
			cmp_byte("mul_flags", ef, o_flags);
			cmp_bit("addr_valid", r.xa != 16'h0000, o_addr_valid);
			if (r.xa != 16'h0000) cmp_word("addr", r.xa, o_addr);
		end
	endtask : run

	task automatic report_and_stop;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : report_and_stop

	// main sequence: table rows first, then the awkward cases
	initial begin
		rows = '{'{0, 8'h02, 2'h0, 16'h1234, 16'h0003, 16'h0000, 8'h00},
			'{0, 8'h12, 2'h0, 16'h4000, 16'hfffe, 16'h0000, 8'h00},
			'{0, 8'h22, 2'h1, 16'h0100, 16'h0100, 16'h0000, 8'h00},
			'{0, 8'h32, 2'h2, 16'h0000, 16'h8000, 16'h0000, 8'h00},
			'{0, 8'h32, 2'h1, 16'h8000, 16'h8000, 16'h0000, 8'h00},
			'{0, 8'h12, 2'h1, 16'hffff, 16'h8000, 16'h0000, 8'h00},
			'{0, 8'h02, 2'h1, 16'h0001, 16'h8000, 16'h0000, 8'h00},
			'{0, 8'h02, 2'h2, 16'h0002, 16'h8000, 16'h1010, 8'h00},
			'{0, 8'h12, 2'h2, 16'h0003, 16'h8000, 16'h2010, 8'h00},
			'{1, 8'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'h01},
			'{1, 8'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'h80},
			'{1, 8'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'h00},
			'{1, 8'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'h10},
			'{1, 8'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'h7f},
			'{1, 8'h00, 2'h0, 16'h0000, 16'h0000, 16'h0000, 8'hf0}};
		repeat (10) @(negedge i_clk);
		cmp_bit("rst_done", 1'b0, o_done);
		cmp_byte("rst_flags", 8'h00, o_flags);
		// one quiet edge after release before the first start
		i_rst_n = 1;
		@(negedge i_clk);
		cmp_bit("rel_done", 1'b0, o_done);
		foreach (rows[k]) run(rows[k], k[0] ? 8'h3a : 8'hc5);
		// bad low field, then a plain-prefix 110 source: both refused, product kept
		i_neg_acc = 0;
		i_opcode = 8'h13;
		@(negedge i_clk);
		cmp_bit("illegal", 1'b1, o_illegal);
		i_opcode = 8'h32;
		@(negedge i_clk);
		i_start = 0;
		cmp_bit("illegal_src", 1'b1, o_illegal);
		cmp_bit("ill_done", 1'b0, o_done);
		cmp_word("ill_low", 16'h8000, o_primary_word);
		cmp_word("ill_high", 16'hfffe, o_extension_word);
		// enable low freezes everything: a pending negate of 55 must not land
		i_ce = 0;
		i_start = 1;
		i_neg_acc = 1;
		i_acc = 8'h55;
		@(negedge i_clk);
		cmp_bit("ce_done", 1'b0, o_done);
		cmp_bit("ce_illegal", 1'b1, o_illegal);
		cmp_byte("ce_acc", 8'h10, o_acc);
		i_start = 0;
		i_ce = 1;
		// second reset in mid-run clears the held results
		i_rst_n = 0;
		@(negedge i_clk);
		cmp_word("rst_low", 16'h0000, o_primary_word);
		cmp_byte("rst_acc", 8'h00, o_acc);
		// release again: quiet first edge, then a negate must still work
		i_rst_n = 1;
		@(negedge i_clk);
		cmp_bit("rel2_done", 1'b0, o_done);
		run(rows[9], 8'h3a);
		report_and_stop;
	end

	// watchdog: the sequence needs under 50 cycles
	initial begin
		#(5 * 400);
		num_errors++;
		report_and_stop;
	end
endmodule : signed_word_multiply_negate_tb
`default_nettype wire
